// ---- src/cross_trigger_consts.vh ----
// constants for the cross trigger event unit
`ifndef CROSS_TRIGGER_CONSTS_VH
`define CROSS_TRIGGER_CONSTS_VH

`define CT_NUM_TRIG       32
`define CT_NUM_CHAN       4
`define CT_MUX_W          8
`define CT_ADDR_W         12
`define CT_DATA_W         32

`define CT_REG_CONTROL    12'h000
`define CT_REG_ACK        12'h004
`define CT_REG_GATE       12'h008
`define CT_REG_MUXCTRL    12'h00C
`define CT_REG_TRIGIN_ST  12'h010
`define CT_REG_TRIGOUT_ST 12'h014
`define CT_REG_CHIN_ST    12'h018
`define CT_REG_CHOUT_ST   12'h01C
`define CT_REG_APPPULSE   12'h020

`define CT_PAGE_HI        11
`define CT_PAGE_LO        8
`define CT_PAGE_INMAP     4'h1
`define CT_PAGE_OUTMAP    4'h2
`define CT_IDX_HI         6
`define CT_IDX_LO         2

`define CT_ENABLE_BIT     0
`define CT_RST_CONTROL    1'h0
`define CT_RST_GATE       4'hF
`define CT_RST_MUX        8'h00
`define CT_RST_MAP        4'h0

`endif

// ---- src/cross_trigger_unit.v ----
// cross trigger event unit: trigger inputs to channels to trigger outputs
`timescale 1ns/1ns
`default_nettype none
`include "cross_trigger_consts.vh"

// Contract
// [RL1] thirty-two trigger inputs and thirty-two outputs
// [RL2] each input maps onto any of four channels
// [RL3] raised channel events leave toward the matrix
// [RL4] each channel maps onto any trigger output
// [RL5] per-channel broadcast gate keeps events local
// [RL6] matrix holds no state; mapping lives here
// [RL7] input tie-off selects pulse or level input
// [RL8] output tie-off selects pulse or acknowledged level
// [RL9] req-ack sources arrive as single pulses
// [RL10] crossings deliver an event for one cycle
// [RL11] coinciding channel events are ORed together
// [RL12] close events may merge into one
// [RL13] global enable stops propagation, keeps mapping
// [RL14] eight mux control outputs from a register
// [RL15] matrix fan-in up to thirty-three, cascadable
// [RL16] authentication inputs gate event passage
// [RL17] registers reached over the register port
// [RL18] level inputs cross via two-flop synchronizer
// [RL19] register stage on level event outputs
// [RL20] matrix channel is OR of other units
module cross_trigger_unit (
  // clock and reset
  input  wire                      clk_i,
  input  wire                      nrst_i,
  // register port
  input  wire [`CT_ADDR_W-1:0]     addr_i,
  input  wire [`CT_DATA_W-1:0]     wdata_i,
  input  wire                      we_i,
  input  wire                      re_i,
  output reg  [`CT_DATA_W-1:0]     rdata_o,
  // trigger side
  input  wire [`CT_NUM_TRIG-1:0]   trig_in_i,
  input  wire [`CT_NUM_TRIG-1:0]   input_level_select_i,
  input  wire [`CT_NUM_TRIG-1:0]   output_level_select_i,
  output reg  [`CT_NUM_TRIG-1:0]   trig_out_o,
  // channel side toward the matrix
  input  wire [`CT_NUM_CHAN-1:0]   chan_in_i,
  output reg  [`CT_NUM_CHAN-1:0]   chan_out_o,
  // authentication
  input  wire                      auth_invasive_i,
  input  wire                      auth_noninvasive_i,
  // external multiplexer steering
  output reg  [`CT_MUX_W-1:0]      external_mux_control_o
);

  function hit;
    input [`CT_NUM_CHAN-1:0] map;
    input [`CT_NUM_CHAN-1:0] chan;
    begin
      hit = |(map & chan);
    end
  endfunction

  reg  [`CT_NUM_TRIG-1:0] tin_s1_r;
  reg  [`CT_NUM_TRIG-1:0] tin_s2_r;
  reg  [`CT_NUM_TRIG-1:0] tin_d_r;
  reg  [`CT_NUM_TRIG-1:0] ilvl_s1_r;
  reg  [`CT_NUM_TRIG-1:0] ilvl_s2_r;
  reg  [`CT_NUM_TRIG-1:0] olvl_s1_r;
  reg  [`CT_NUM_TRIG-1:0] olvl_s2_r;
  reg  [1:0]              auth_s1_r;
  reg  [1:0]              auth_s2_r;
  reg                     enable_r;
  reg  [`CT_NUM_CHAN-1:0] gate_r;
  reg  [`CT_NUM_CHAN-1:0] app_pulse_r;
  reg  [`CT_NUM_CHAN-1:0] chan_d_r;
  reg  [`CT_NUM_CHAN-1:0] in_map_r  [0:`CT_NUM_TRIG-1];
  reg  [`CT_NUM_CHAN-1:0] out_map_r [0:`CT_NUM_TRIG-1];

  reg  [`CT_NUM_TRIG-1:0] in_evt;
  reg  [`CT_NUM_CHAN-1:0] raised;
  reg  [`CT_NUM_CHAN-1:0] chan;
  reg  [`CT_NUM_CHAN-1:0] chan_rise;
  reg  [`CT_NUM_TRIG-1:0] ack;
  reg  [`CT_NUM_TRIG-1:0] trig_out_nxt;
  reg  [`CT_NUM_CHAN-1:0] chan_out_nxt;
  reg  [`CT_DATA_W-1:0]   rdata_nxt;
  integer                 i;

  wire                    map_wr;
  wire [`CT_PAGE_HI-`CT_PAGE_LO:0] page;
  wire [`CT_IDX_HI-`CT_IDX_LO:0]   idx;

  assign page   = addr_i[`CT_PAGE_HI:`CT_PAGE_LO];
  assign idx    = addr_i[`CT_IDX_HI:`CT_IDX_LO];
  assign map_wr = we_i;

  // input synchronizers for pins and tie-offs
  always @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      tin_s1_r  <= {`CT_NUM_TRIG{1'b0}};
      tin_s2_r  <= {`CT_NUM_TRIG{1'b0}};
      tin_d_r   <= {`CT_NUM_TRIG{1'b0}};
      ilvl_s1_r <= {`CT_NUM_TRIG{1'b0}};
      ilvl_s2_r <= {`CT_NUM_TRIG{1'b0}};
      olvl_s1_r <= {`CT_NUM_TRIG{1'b0}};
      olvl_s2_r <= {`CT_NUM_TRIG{1'b0}};
      auth_s1_r <= 2'h0;
      auth_s2_r <= 2'h0;
    end
    else
    begin
      tin_s1_r  <= trig_in_i;                          // RL18
      tin_s2_r  <= tin_s1_r;                           // RL18
      tin_d_r   <= tin_s2_r;
      ilvl_s1_r <= input_level_select_i;
      ilvl_s2_r <= ilvl_s1_r;
      olvl_s1_r <= output_level_select_i;
      olvl_s2_r <= olvl_s1_r;
      auth_s1_r <= {auth_invasive_i, auth_noninvasive_i};
      auth_s2_r <= auth_s1_r;
    end
  end

  // event mapping datapath
  always @*
  begin
    in_evt       = {`CT_NUM_TRIG{1'b0}};
    raised       = {`CT_NUM_CHAN{1'b0}};
    chan         = {`CT_NUM_CHAN{1'b0}};
    chan_rise    = {`CT_NUM_CHAN{1'b0}};
    ack          = {`CT_NUM_TRIG{1'b0}};
    trig_out_nxt = {`CT_NUM_TRIG{1'b0}};
    chan_out_nxt = {`CT_NUM_CHAN{1'b0}};
    if (we_i && addr_i == `CT_REG_ACK)
      ack = wdata_i;
    for (i = 0; i < `CT_NUM_TRIG; i = i + 1)
    begin
      // pulse inputs count first cycle only; req-ack sources arrive as pulses
      in_evt[i] = ilvl_s2_r[i] ? tin_s2_r[i] : (tin_s2_r[i] & ~tin_d_r[i]); // RL7 RL9
    end
    in_evt = in_evt & {`CT_NUM_TRIG{enable_r & auth_s2_r[0]}}; // RL13 RL16
    for (i = 0; i < `CT_NUM_TRIG; i = i + 1)
    begin
      raised = raised | (in_map_r[i] & {`CT_NUM_CHAN{in_evt[i]}}); // RL2
    end
    raised = raised | app_pulse_r;
    if (enable_r)
    begin
      chan_out_nxt = raised & gate_r;                  // RL3 RL5
      chan         = raised | chan_in_i;               // RL11 RL20
    end
    // overlapping channel events merge into one output edge
    chan_rise = chan & ~chan_d_r;                      // RL10 RL12
    for (i = 0; i < `CT_NUM_TRIG; i = i + 1)
    begin
      if (olvl_s2_r[i])
        trig_out_nxt[i] = (trig_out_o[i] & ~ack[i]) | hit(out_map_r[i], chan); // RL8
      else
        trig_out_nxt[i] = hit(out_map_r[i], chan_rise); // RL4 RL8
    end
    if (!auth_s2_r[1])
      trig_out_nxt = {`CT_NUM_TRIG{1'b0}};             // RL16
  end

  // read mux
  always @*
  begin
    rdata_nxt = {`CT_DATA_W{1'b0}};
    if (page == `CT_PAGE_INMAP)
      rdata_nxt[`CT_NUM_CHAN-1:0] = in_map_r[idx];
    else if (page == `CT_PAGE_OUTMAP)
      rdata_nxt[`CT_NUM_CHAN-1:0] = out_map_r[idx];
    else
    begin
      case (addr_i)
        `CT_REG_CONTROL:    rdata_nxt[`CT_ENABLE_BIT] = enable_r;
        `CT_REG_GATE:       rdata_nxt[`CT_NUM_CHAN-1:0] = gate_r;
        `CT_REG_MUXCTRL:    rdata_nxt[`CT_MUX_W-1:0] = external_mux_control_o;
        `CT_REG_TRIGIN_ST:  rdata_nxt = tin_s2_r;
        `CT_REG_TRIGOUT_ST: rdata_nxt = trig_out_o;
        `CT_REG_CHIN_ST:    rdata_nxt[`CT_NUM_CHAN-1:0] = chan_in_i;
        `CT_REG_CHOUT_ST:   rdata_nxt[`CT_NUM_CHAN-1:0] = chan_out_o;
        default:            rdata_nxt = {`CT_DATA_W{1'b0}};
      endcase
    end
  end

  // control registers and outputs
  always @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      enable_r               <= `CT_RST_CONTROL;
      gate_r                 <= `CT_RST_GATE;
      app_pulse_r            <= {`CT_NUM_CHAN{1'b0}};
      chan_d_r               <= {`CT_NUM_CHAN{1'b0}};
      external_mux_control_o <= `CT_RST_MUX;
      trig_out_o             <= {`CT_NUM_TRIG{1'b0}};
      chan_out_o             <= {`CT_NUM_CHAN{1'b0}};
      rdata_o                <= {`CT_DATA_W{1'b0}};
    end
    else
    begin
      app_pulse_r <= {`CT_NUM_CHAN{1'b0}};
      if (we_i)
      begin
        case (addr_i)                                  // RL17
          `CT_REG_CONTROL:  enable_r <= wdata_i[`CT_ENABLE_BIT]; // RL13
          `CT_REG_GATE:     gate_r <= wdata_i[`CT_NUM_CHAN-1:0]; // RL5
          `CT_REG_MUXCTRL:  external_mux_control_o <= wdata_i[`CT_MUX_W-1:0]; // RL14
          `CT_REG_APPPULSE: app_pulse_r <= wdata_i[`CT_NUM_CHAN-1:0];
          default:          app_pulse_r <= {`CT_NUM_CHAN{1'b0}};
        endcase
      end
      chan_d_r   <= chan;
      trig_out_o <= trig_out_nxt;                      // RL19
      chan_out_o <= chan_out_nxt;                      // RL15
      if (re_i)
        rdata_o <= rdata_nxt;
      else
        rdata_o <= {`CT_DATA_W{1'b0}};
    end
  end

  // mapping storage; cleared at reset, kept across enable changes
  always @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      for (i = 0; i < `CT_NUM_TRIG; i = i + 1)
      begin
        in_map_r[i]  <= `CT_RST_MAP;
        out_map_r[i] <= `CT_RST_MAP;
      end
    end
    else if (map_wr)
    begin
      if (page == `CT_PAGE_INMAP)
        in_map_r[idx] <= wdata_i[`CT_NUM_CHAN-1:0];    // RL1 RL6
      if (page == `CT_PAGE_OUTMAP)
        out_map_r[idx] <= wdata_i[`CT_NUM_CHAN-1:0];   // RL1 RL4
    end
  end

endmodule
`default_nettype wire

// ---- tb/cross_trigger_event_network_test.sv ----
// testbench for the cross trigger unit
`timescale 1ns/1ns
`default_nettype none
`include "cross_trigger_consts.vh"
module cross_trigger_event_network_test;
  logic        clk_i = 0, nrst_i = 0, we_i = 0, re_i = 0, auth_inv = 1, auth_non = 1;
  logic [11:0] addr_i = 12'h0;
  logic [31:0] wdata_i = 32'h0, rdata_o, trig_in = 32'h0, ilvl = 32'h0, olvl = 32'h0, trig_out;
  logic [3:0]  chan_in, chan_out, raise = 4'h0, seen;
  logic [7:0]  mux;
  int          fail_count = 0, checks = 0;
  always #5 clk_i = ~clk_i;
  cross_trigger_unit dut (.clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o), .trig_in_i(trig_in),
    .input_level_select_i(ilvl), .output_level_select_i(olvl), .trig_out_o(trig_out),
    .chan_in_i(chan_in), .chan_out_o(chan_out), .auth_invasive_i(auth_inv),
    .auth_noninvasive_i(auth_non), .external_mux_control_o(mux));
  peer_matrix_model peer (.clk_i(clk_i), .nrst_i(nrst_i), .raise_i(raise),
    .dut_chan_i(chan_out), .chan_o(chan_in), .seen_o(seen));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    we_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    we_i <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    @(posedge clk_i);
    re_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    re_i <= 1'b0;
    #1;
    chk("rdata", exp, rdata_o);
  endtask
  task automatic fire(input bit from_chan, input int et, input int ec);
    int t = 0, c = 0;
    @(posedge clk_i);
    raise <= {3'h0, from_chan};
    trig_in <= {31'h0, !from_chan};
    @(posedge clk_i);
    raise <= 4'h0;
    trig_in <= 32'h0;
    repeat (12)
    begin
      @(posedge clk_i);
      #1;
      t += (trig_out[1] === 1'b1);
      c += (chan_out[0] === 1'b1);
    end
    chk("trig_out_1 cycles", et, t);
    chk("chan_out_0 cycles", ec, c);
  endtask
  task automatic app_fire(input int et, input int ec);
    int t = 0, c = 0;
    wr(`CT_REG_APPPULSE, 32'h1);
    repeat (6)
    begin
      @(posedge clk_i);
      #1;
      t += (trig_out[1] === 1'b1);
      c += (chan_out[0] === 1'b1);
    end
    chk("app trig_out_1 cycles", et, t);
    chk("app chan_out_0 cycles", ec, c);
  endtask
  task automatic end_sim;
    $display("fail_count=%0d checks=%0d", fail_count, checks);
    if (fail_count == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (12) @(posedge clk_i);
    nrst_i <= 1'b1;
    rd(`CT_REG_CONTROL, 32'h0);
    rd(`CT_REG_GATE, 32'hF);
    rd(12'hFFC, 32'h0);
    wr(`CT_REG_MUXCTRL, 32'hA5);
    #1;
    chk("mux", 32'hA5, {24'h0, mux});
    wr(12'h100, 32'h1);
    wr(12'h204, 32'h1);
    fire(0, 0, 0);
    rd(12'h100, 32'h1);
    wr(`CT_REG_CONTROL, 32'h1);
    fire(0, 1, 1);
    chk("peer seen", 32'h1, {28'h0, seen});
    fire(1, 1, 0);
    wr(`CT_REG_GATE, 32'hE);
    fire(0, 1, 0);
    wr(`CT_REG_GATE, 32'hF);
    auth_non <= 1'b0;
    repeat (4) @(posedge clk_i);
    fire(0, 0, 0);
    auth_non <= 1'b1;
    repeat (4) @(posedge clk_i);
    app_fire(1, 1);
    olvl <= 32'hFFFFFFFF;
    repeat (4) @(posedge clk_i);
    fire(1, 12, 0);
    wr(`CT_REG_ACK, 32'h2);
    @(posedge clk_i);
    #1;
    chk("acked output", 32'h0, {31'h0, trig_out[1]});
    @(posedge clk_i);
    olvl <= 32'h0;
    auth_inv <= 1'b0;
    repeat (4) @(posedge clk_i);
    fire(1, 0, 0);
    @(posedge clk_i);
    auth_inv <= 1'b1;
    ilvl <= 32'h1;
    repeat (4) @(posedge clk_i);
    trig_in <= 32'h1;
    repeat (12) @(posedge clk_i);
    #1;
    chk("level channel", 32'h1, {31'h0, chan_out[0]});
    rd(`CT_REG_TRIGIN_ST, 32'h1);
    rd(`CT_REG_CHOUT_ST, 32'h1);
    rd(`CT_REG_CHIN_ST, 32'h0);
    rd(`CT_REG_TRIGOUT_ST, 32'h0);
    @(posedge clk_i);
    trig_in <= 32'h0;
    end_sim;
  end
endmodule
bind cross_trigger_unit cross_trigger_props chk (.clk_i(clk_i), .nrst_i(nrst_i), .we_i(we_i),
  .re_i(re_i), .auth_invasive_i(auth_invasive_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .rdata_o(rdata_o), .input_level_select_i(input_level_select_i), .trig_out_o(trig_out_o),
  .output_level_select_i(output_level_select_i), .chan_out_o(chan_out_o),
  .external_mux_control_o(external_mux_control_o));
`default_nettype wire

// ---- tb/cross_trigger_props.sv ----
// port checker for the cross trigger unit
`timescale 1ns/1ns
`default_nettype none
`include "cross_trigger_consts.vh"
module cross_trigger_props (
  // clock, reset, authentication, register port and input tie-off
  input wire logic        clk_i, nrst_i, we_i, re_i, auth_invasive_i,
  input wire logic [11:0] addr_i,
  input wire logic [31:0] wdata_i, rdata_o, input_level_select_i,
  // trigger and channel side
  input wire logic [31:0] output_level_select_i, trig_out_o,
  input wire logic [3:0]  chan_out_o,
  input wire logic [7:0]  external_mux_control_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  a_rdata_idle: assert property (!$past(re_i) |-> rdata_o == 32'h0)
    else $error("read data outside slot");
  a_unmapped_read: assert property (re_i && addr_i == 12'hFFC |=> rdata_o == 32'h0)
    else $error("unmapped read not zero");
  a_mux_write: assert property (we_i && addr_i == `CT_REG_MUXCTRL |=>
    external_mux_control_o == $past(wdata_i[7:0])) else $error("mux not written");
  a_mux_hold: assert property (!$past(we_i) |-> $stable(external_mux_control_o))
    else $error("mux changed without write");
  a_auth_block: assert property ((!auth_invasive_i) [*4] |-> trig_out_o == 32'h0)
    else $error("output while not allowed");
  a_pulse_out: assert property ((output_level_select_i == 32'h0) [*4] |->
    (trig_out_o & $past(trig_out_o)) == 32'h0) else $error("pulse output too long");
  a_level_hold: assert property ((&output_level_select_i && auth_invasive_i) [*4]
    ##0 !we_i |=> (trig_out_o & $past(trig_out_o)) == $past(trig_out_o))
    else $error("level output dropped");
  a_in_pulse: assert property ((input_level_select_i == 32'h0 && !we_i) [*6] |->
    (chan_out_o & $past(chan_out_o)) == 4'h0) else $error("pulse input held channel");
endmodule
`default_nettype wire

// ---- tb/peer_matrix_model.sv ----
// far side model: matrix joined to one peer unit
`timescale 1ns/1ns
`default_nettype none
module peer_matrix_model (
  // clock, reset and peer events
  input  wire logic       clk_i, nrst_i,
  input  wire logic [3:0] raise_i,
  // channels
  input  wire logic [3:0] dut_chan_i,
  output var  logic [3:0] chan_o, seen_o
);
  always @(posedge clk_i)
  begin
    chan_o <= raise_i;
    seen_o <= nrst_i ? (seen_o | dut_chan_i) : 4'h0;
  end
endmodule
`default_nettype wire
